// File: logic/timer_group.sv
// Three-timer group: core timer, two auxiliary timers, registers, irq

module timer_group import timer_group_pkg::*; (
  input wire logic CLK,
  input wire logic RESET,
  input wire logic [ADDR_W-1:0] ADDR,
  input wire logic [W-1:0] WDATA,
  input wire logic WR,
  input wire logic RD,
  output logic [W-1:0] RDATA,
  input wire logic [NT-1:0] COUNT_IN,
  input wire logic [NT-1:0] DIR_IN,
  output logic TOGGLE_OUT,
  output logic TOGGLE_OE,
  output logic IRQ
);
  logic [W-1:0] ctrl_reg [NT];
  logic [W-1:0] val [NT];
  logic [W-1:0] ld_val [NT];
  logic [W-1:0] rdata_reg;
  logic [NST-1:0] status_reg, mask_reg, st_set, st_clr;
  logic latch_reg, latch_q_reg, pin_en_reg;
  logic [DIV_W-1:0] div_reg;
  logic [NT-1:0] cin, din, cin_q_reg, din_q_reg;
  logic [NT-1:0] en, up, ld, wrap, in_edge, ev;
  logic [NT-1:0] pend_reg, pend_up_reg, cap, rl, vwr;
  logic base_tick, latch_rise, latch_fall, latch_tog, latch_wr;

  timer_if tif [NT] ();

  // ----------------------------------------
  // Input synchronisers
  // ----------------------------------------
  pin_sync #(.N(2 * NT)) u_sync (
    .clk(CLK),
    .reset(RESET),
    .pin_in({DIR_IN, COUNT_IN}),
    .pin_out({din, cin})
  );

  always_ff @(posedge CLK) begin
    if (RESET) begin
      cin_q_reg <= '0;
      din_q_reg <= '0;
    end else begin
      cin_q_reg <= cin;
      din_q_reg <= din;
    end
  end

  // ----------------------------------------
  // Base divider
  // ----------------------------------------
  always_ff @(posedge CLK) begin
    if (RESET) begin
      div_reg <= '0;
    end else begin
      div_reg <= div_reg + 1'b1;
    end
  end

  assign base_tick = (div_reg[BASE_LOG2-1:0] == '0);

  // ----------------------------------------
  // Core toggle latch
  // ----------------------------------------
  assign latch_wr = WR && (ADDR == A_LATCH);

  always_ff @(posedge CLK) begin
    if (RESET) begin
      latch_reg <= 1'b0;
      pin_en_reg <= 1'b0;
    end else if (latch_wr) begin
      latch_reg <= WDATA[LT_STATE];
      pin_en_reg <= WDATA[LT_OE];
    end else if (wrap[0]) begin
      latch_reg <= ~latch_reg;
    end
  end

  always_ff @(posedge CLK) begin
    if (RESET) begin
      latch_q_reg <= 1'b0;
    end else begin
      latch_q_reg <= latch_reg;
    end
  end

  assign latch_rise = latch_reg & ~latch_q_reg;
  assign latch_fall = ~latch_reg & latch_q_reg;
  assign latch_tog = latch_rise | latch_fall;
  assign TOGGLE_OUT = latch_reg;
  assign TOGGLE_OE = pin_en_reg;

  // ----------------------------------------
  // Per-timer count control
  // ----------------------------------------
  for (genvar g = 0; g < NT; g++) begin : g_tmr
    logic [W-1:0] c;
    logic [PS_W-1:0] ps;
    logic [DIV_W-1:0] pmask;
    logic tick, dir_up, quad_up, quad_ev, gate_ok, run_ok;
    mode_t mode;
    func_t func;

    assign c = ctrl_reg[g];
    assign mode = mode_t'(c[MODE_LSB +: 2]);
    assign func = (g == 0) ? F_NORMAL : func_t'(c[FUNC_LSB +: 2]);
    assign ps = c[PS_LSB +: PS_W];
    assign pmask = (DIV_BASE << ps) - 1'b1;
    assign tick = ((div_reg & pmask) == '0);
    assign gate_ok = (cin[g] == c[GATE_LVL]);
    assign dir_up = ~(c[DIR_SW] ^ (c[DIR_EXT] & din[g]));
    assign quad_ev = (cin[g] ^ cin_q_reg[g]) | (din[g] ^ din_q_reg[g]);
    assign quad_up = cin_q_reg[g] ^ din[g];
    assign in_edge[g] = (cin[g] & ~cin_q_reg[g] & c[EDGE_RISE])
                      | (~cin[g] & cin_q_reg[g] & c[EDGE_FALL]);

    // Event sources; latch clocking chains an aux timer to the core
    always_comb begin
      if (mode == M_INCR) begin
        ev[g] = quad_ev;
      end else if (mode == M_COUNTER) begin
        if (g != 0 && c[LATCH_CLK]) begin
          ev[g] = latch_tog;
        end else begin
          ev[g] = in_edge[g];
        end
      end else begin
        ev[g] = 1'b0;
      end
    end

    // Events wait for the next base tick
    always_ff @(posedge CLK) begin
      if (RESET) begin
        pend_reg[g] <= 1'b0;
        pend_up_reg[g] <= 1'b0;
      end else if (ev[g]) begin
        pend_reg[g] <= 1'b1;
        pend_up_reg[g] <= (mode == M_INCR) ? quad_up : dir_up;
      end else if (base_tick) begin
        pend_reg[g] <= 1'b0;
      end
    end

    assign run_ok = c[RUN] & (func == F_NORMAL);

    always_comb begin
      case (mode)
        M_TIMER: en[g] = run_ok & tick;
        M_GATED: en[g] = run_ok & tick & gate_ok;
        default: en[g] = run_ok & pend_reg[g] & base_tick;
      endcase
    end

    assign up[g] = (mode == M_TIMER || mode == M_GATED) ? dir_up
                 : pend_up_reg[g];
    assign cap[g] = (func == F_CAPTURE) & in_edge[g];
    assign rl[g] = (func == F_RELOAD) & (in_edge[g]
                 | (c[RLD_RISE] & latch_rise)
                 | (c[RLD_FALL] & latch_fall));
    assign vwr[g] = WR && (ADDR == A_VAL0 + ADDR_W'(g));

    assign tif[g].en = en[g];
    assign tif[g].up = up[g];
    assign tif[g].ld = ld[g];
    assign tif[g].ld_val = ld_val[g];
    assign val[g] = tif[g].val;
    assign wrap[g] = tif[g].ovf | tif[g].unf;

    timer_unit u_unit (
      .clk(CLK),
      .reset(RESET),
      .t(tif[g])
    );
  end

  // ----------------------------------------
  // Load paths: software, capture, reload
  // ----------------------------------------
  always_comb begin
    ld[0] = vwr[0] | rl[1] | rl[2];
    if (vwr[0]) begin
      ld_val[0] = WDATA;
    end else if (rl[1]) begin
      ld_val[0] = val[1];
    end else begin
      ld_val[0] = val[2];
    end
    for (int k = 1; k < NT; k++) begin
      ld[k] = vwr[k] | cap[k];
      ld_val[k] = vwr[k] ? WDATA : val[0];
    end
  end

  // ----------------------------------------
  // Control registers
  // ----------------------------------------
  always_ff @(posedge CLK) begin
    if (RESET) begin
      for (int k = 0; k < NT; k++) begin
        ctrl_reg[k] <= CTRL_RST;
      end
      mask_reg <= '0;
    end else if (WR) begin
      for (int k = 0; k < NT; k++) begin
        if (ADDR == A_CTRL0 + ADDR_W'(k)) begin
          ctrl_reg[k] <= WDATA;
        end
      end
      if (ADDR == A_MASK) begin
        mask_reg <= WDATA[NST-1:0];
      end
    end
  end

  // ----------------------------------------
  // Status and interrupt
  // ----------------------------------------
  assign st_set = {cap[2], cap[1], wrap};
  assign st_clr = (WR && ADDR == A_STATUS) ? WDATA[NST-1:0] : '0;

  always_ff @(posedge CLK) begin
    if (RESET) begin
      status_reg <= '0;
    end else begin
      status_reg <= (status_reg & ~st_clr) | st_set;
    end
  end

  assign IRQ = |(status_reg & mask_reg);

  // ----------------------------------------
  // Read port
  // ----------------------------------------
  always_ff @(posedge CLK) begin
    if (RESET || !RD) begin
      rdata_reg <= '0;
    end else if (ADDR < A_VAL0) begin
      rdata_reg <= ctrl_reg[2'(ADDR - A_CTRL0)];
    end else if (ADDR < A_STATUS) begin
      rdata_reg <= val[2'(ADDR - A_VAL0)];
    end else if (ADDR == A_STATUS) begin
      rdata_reg <= W'(status_reg);
    end else if (ADDR == A_MASK) begin
      rdata_reg <= W'(mask_reg);
    end else if (ADDR == A_LATCH) begin
      rdata_reg <= W'({pin_en_reg, latch_reg});
    end else begin
      rdata_reg <= '0;
    end
  end

  assign RDATA = rdata_reg;

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  default clocking cb @(posedge CLK); endclocking
  default disable iff (RESET);

  core_res_a: assert property (
    en[0] |=> !en[0] [*3])
    else $error("core counted faster than resolution");

  aux_res_a: assert property (
    en[1] |=> !en[1] [*3])
    else $error("aux a counted faster than resolution");

  wrap_up_a: assert property (
    (en[0] && up[0] && !ld[0] && val[0] == ALL_ONES)
    |=> (val[0] == '0) && status_reg[0])
    else $error("overflow did not wrap to zero");

  wrap_down_a: assert property (
    (en[0] && !up[0] && !ld[0] && val[0] == '0)
    |=> (val[0] == ALL_ONES) && status_reg[0])
    else $error("underflow did not wrap to all ones");

  latch_flip_a: assert property (
    (wrap[0] && !latch_wr) |=> (latch_reg != $past(latch_reg)))
    else $error("toggle latch missed a wrap");

  capture_val_a: assert property (
    (cap[1] && !vwr[1]) |=> (val[1] == $past(val[0]))
      && status_reg[ST_CAP_A])
    else $error("capture did not copy core value");

  reload_val_a: assert property (
    (rl[1] && !vwr[0]) |=> (val[0] == $past(val[1])))
    else $error("reload did not load core");

  aux_stop_a: assert property (
    (g_tmr[2].func != F_NORMAL && !ld[2])
    |=> (val[2] == $past(val[2])))
    else $error("aux b counted while capture or reload");

  gate_level_a: assert property (
    (g_tmr[0].mode == M_GATED && !ld[0]
      && cin[0] != ctrl_reg[0][GATE_LVL])
    |=> (val[0] == $past(val[0])))
    else $error("gated timer counted with gate inactive");

  capture_b_a: assert property (
    (cap[2] && !vwr[2]) |=> (val[2] == $past(val[0]))
      && status_reg[ST_CAP_B])
    else $error("capture did not copy core value to aux b");

  status_set_a: assert property (
    (|st_set) |=> ((status_reg & $past(st_set)) == $past(st_set)))
    else $error("status event lost");

  count_event_a: assert property (
    (g_tmr[0].mode == M_COUNTER && ctrl_reg[0][RUN] && ev[0]
      && !latch_wr)
    |-> ##[1:4] en[0])
    else $error("counter event not counted in time");

  // ----------------------------------------
  // Cover points
  // ----------------------------------------
  wrap_c: cover property (wrap[0] ##1 latch_tog);
  capture_c: cover property (cap[1]);
  pwm_c: cover property (rl[1] ##[1:300] rl[2]);
  gated_c: cover property (g_tmr[0].mode == M_GATED && en[0]);
  quad_down_c: cover property (g_tmr[0].mode == M_INCR && en[0] && !up[0]);
endmodule // timer_group

// File: logic/timer_group_pkg.sv
// Constants and types shared by the three-timer group
package timer_group_pkg;
  localparam int W = 16;
  localparam int NT = 3;
  localparam int ADDR_W = 4;
  localparam logic [W-1:0] ALL_ONES = 16'hFFFF;
  localparam logic [W-1:0] CTRL_RST = 16'h0000;
  // Timing
  localparam int CLK_PERIOD_NS = 4;
  localparam int MIN_RES_CYCLES = 4;
  localparam int BASE_LOG2 = $clog2(MIN_RES_CYCLES);
  localparam int PS_W = 3;
  localparam int DIV_W = BASE_LOG2 + (1 << PS_W);
  localparam logic [DIV_W-1:0] DIV_BASE = DIV_W'(MIN_RES_CYCLES);
  // Register indexes
  localparam logic [ADDR_W-1:0] A_CTRL0 = 4'h0;
  localparam logic [ADDR_W-1:0] A_VAL0 = 4'h3;
  localparam logic [ADDR_W-1:0] A_STATUS = 4'h6;
  localparam logic [ADDR_W-1:0] A_MASK = 4'h7;
  localparam logic [ADDR_W-1:0] A_LATCH = 4'h8;
  // Control fields
  localparam int MODE_LSB = 0;
  localparam int DIR_SW = 2;
  localparam int DIR_EXT = 3;
  localparam int RUN = 4;
  localparam int GATE_LVL = 5;
  localparam int PS_LSB = 6;
  localparam int EDGE_RISE = 9;
  localparam int EDGE_FALL = 10;
  localparam int FUNC_LSB = 11;
  localparam int LATCH_CLK = 13;
  localparam int RLD_RISE = 14;
  localparam int RLD_FALL = 15;
  // Status and latch fields
  localparam int NST = 5;
  localparam int ST_CAP_A = 3;
  localparam int ST_CAP_B = 4;
  localparam int LT_STATE = 0;
  localparam int LT_OE = 1;
  typedef enum logic [1:0] {
    M_TIMER = 2'h0, M_GATED = 2'h1, M_COUNTER = 2'h2, M_INCR = 2'h3
  } mode_t;
  typedef enum logic [1:0] {
    F_NORMAL = 2'h0, F_CAPTURE = 2'h1, F_RELOAD = 2'h2, F_SPARE = 2'h3
  } func_t;
endpackage

// File: logic/timer_if.sv
// Control and status bundle between the group and one timer
interface timer_if;
  import timer_group_pkg::*;
  logic en;
  logic up;
  logic ld;
  logic [W-1:0] ld_val;
  logic [W-1:0] val;
  logic ovf;
  logic unf;
  modport ctl (output en, up, ld, ld_val, input val, ovf, unf);
  modport cnt (input en, up, ld, ld_val, output val, ovf, unf);
endinterface

// File: logic/pin_sync.sv
// Three-stage pin synchroniser with agreement filter
module pin_sync import timer_group_pkg::*; #(
  parameter int N = 1
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic [N-1:0] pin_in,
  output logic [N-1:0] pin_out
);
  logic [N-1:0] s1_reg, s2_reg, s3_reg, out_reg;

  always_ff @(posedge clk) begin
    if (reset) begin
      s1_reg <= '0;
      s2_reg <= '0;
      s3_reg <= '0;
      out_reg <= '0;
    end else begin
      s1_reg <= pin_in;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
      // Take a bit only when stages two and three agree
      out_reg <= (s2_reg & s3_reg) | (out_reg & (s2_reg | s3_reg));
    end
  end

  assign pin_out = out_reg;
endmodule // pin_sync

// File: logic/timer_unit.sv
// One 16-bit up/down timer with load and wrap flags
module timer_unit import timer_group_pkg::*; (
  input wire logic clk,
  input wire logic reset,
  timer_if.cnt t
);
  logic [W-1:0] val_reg;

  always_ff @(posedge clk) begin
    if (reset) begin
      val_reg <= '0;
    end else if (t.ld) begin
      val_reg <= t.ld_val;
    end else if (t.en) begin
      val_reg <= t.up ? val_reg + 1'b1 : val_reg - 1'b1;
    end
  end

  assign t.val = val_reg;
  assign t.ovf = t.en & ~t.ld & t.up & (val_reg == ALL_ONES);
  assign t.unf = t.en & ~t.ld & ~t.up & (val_reg == '0);
endmodule // timer_unit

// File: verification/ext_sensor_model.sv
// Behavioural model of the pins driven from outside the timer group
module ext_sensor_model (
  input wire logic clk,
  input wire logic [2:0] pulse_req,
  input wire logic [2:0] lvl,
  input wire logic [2:0] dir_lvl,
  input wire logic quad_on,
  input wire logic quad_step,
  input wire logic quad_fwd,
  output logic [2:0] count_pin,
  output logic [2:0] dir_pin
);
  timeunit 1ns;
  timeprecision 1ps;
  // ----------------------------------------
  // Pulse stretch and quadrature phase
  // ----------------------------------------
  logic [3:0] hold [3] = '{4'h0, 4'h0, 4'h0};
  logic [1:0] phase = 2'h0;
  always @(posedge clk) begin
    for (int i = 0; i < 3; i++) begin
      if (pulse_req[i]) begin
        hold[i] <= 4'h8;
      end else if (hold[i] != 4'h0) begin
        hold[i] <= hold[i] - 4'h1;
      end
    end
    if (quad_step) begin
      phase <= quad_fwd ? phase + 2'h1 : phase - 2'h1;
    end
  end
  always_comb begin
    for (int i = 0; i < 3; i++) begin
      count_pin[i] = lvl[i] ^ (hold[i] != 4'h0);
    end
    dir_pin = dir_lvl;
    if (quad_on) begin
      count_pin[0] = phase[1];
      dir_pin[0] = phase[1] ^ phase[0];
    end
  end
endmodule // ext_sensor_model

// File: verification/test_timer_group.sv
// Self-checking bench for the three-timer group
module test_timer_group import timer_group_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  // ----------------------------------------
  // Signals and instances
  // ----------------------------------------
  logic clk = 1'b0;
  logic reset = 1'b1;
  logic [ADDR_W-1:0] addr = 4'h0;
  logic [W-1:0] wdata = 16'h0000;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic [W-1:0] rdata;
  logic [NT-1:0] count_in;
  logic [NT-1:0] dir_in;
  logic [NT-1:0] pulse_req = 3'h0;
  logic [NT-1:0] lvl = 3'h0;
  logic [NT-1:0] dir_lvl = 3'h0;
  logic quad_on = 1'b0;
  logic quad_step = 1'b0;
  logic quad_fwd = 1'b1;
  logic toggle_out;
  logic toggle_oe;
  logic irq;
  int error_cnt = 0;
  int total_checks = 0;
  int hi;
  int lo;
  always #2 clk = ~clk;
  timer_group dut_u (.CLK(clk), .RESET(reset), .ADDR(addr), .WDATA(wdata),
    .WR(wr), .RD(rd), .RDATA(rdata), .COUNT_IN(count_in), .DIR_IN(dir_in),
    .TOGGLE_OUT(toggle_out), .TOGGLE_OE(toggle_oe), .IRQ(irq));
  ext_sensor_model sensor_u (.clk(clk), .pulse_req(pulse_req), .lvl(lvl),
    .dir_lvl(dir_lvl), .quad_on(quad_on), .quad_step(quad_step),
    .quad_fwd(quad_fwd), .count_pin(count_in), .dir_pin(dir_in));
  // ----------------------------------------
  // Tasks
  // ----------------------------------------
  function automatic logic [W-1:0] bit_at(input int p);
    return 16'h1 << p;
  endfunction
  task automatic check(input string what, input logic [W-1:0] seen,
                       input logic [W-1:0] exp);
    total_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("unexpected %s: expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic summarize();
    $display("checks %0d mismatches %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  task automatic wreg(input logic [ADDR_W-1:0] a, input logic [W-1:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
    #1;
  endtask
  task automatic expect_reg(input string what, input logic [ADDR_W-1:0] a,
                            input logic [W-1:0] exp);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    check(what, rdata, exp);
  endtask
  task automatic run_for(input logic [ADDR_W-1:0] a, input logic [W-1:0] c,
                         input int n);
    wreg(a, c | bit_at(RUN));
    repeat (n - 2) @(posedge clk);
    wreg(a, c);
  endtask
  task automatic pulse(input int i);
    @(posedge clk);
    pulse_req <= 3'(1 << i);
    @(posedge clk);
    pulse_req <= 3'h0;
    repeat (20) @(posedge clk);
  endtask
  task automatic quad(input int n, input logic fwd);
    repeat (n) begin
      @(posedge clk);
      quad_step <= 1'b1;
      quad_fwd <= fwd;
      @(posedge clk);
      quad_step <= 1'b0;
      repeat (12) @(posedge clk);
    end
  endtask
  task automatic measure(input logic lv, output int n);
    n = 0;
    while (toggle_out === lv && n < 400) begin
      @(posedge clk);
      #1;
      n++;
    end
    if (n >= 400) begin
      error_cnt++;
      summarize();
    end
  endtask
  // ----------------------------------------
  // Test sequence
  // ----------------------------------------
  initial begin
    repeat (3) @(posedge clk);
    reset <= 1'b0;
    expect_reg("ctrl core", A_CTRL0, 16'h0000);
    expect_reg("status", A_STATUS, 16'h0000);
    expect_reg("unmapped", 4'hF, 16'h0000);
    @(posedge clk);
    #1;
    check("rdata idle", rdata, 16'h0000);
    check("pin enable", 16'(toggle_oe), 16'h0000);
    $display("test reset done");
    wreg(A_VAL0, 16'hFFFE);
    run_for(A_CTRL0, 16'h0000, 40);
    expect_reg("core up", A_VAL0, 16'h0008);
    check("latch", 16'(toggle_out), 16'h0001);
    check("irq masked", 16'(irq), 16'h0000);
    wreg(A_MASK, 16'h0001);
    check("irq on", 16'(irq), 16'h0001);
    wreg(A_STATUS, 16'h0001);
    check("irq off", 16'(irq), 16'h0000);
    wreg(A_VAL0, 16'h0000);
    run_for(A_CTRL0, 16'h1 << PS_LSB, 40);
    expect_reg("core ps1", A_VAL0, 16'h0005);
    $display("test timer done");
    wreg(A_LATCH, 16'h0002);
    check("latch cleared", 16'(toggle_out), 16'h0000);
    check("pin on", 16'(toggle_oe), 16'h0001);
    wreg(A_CTRL0 + 4'h1, 16'(M_COUNTER) | bit_at(RUN) | bit_at(LATCH_CLK));
    wreg(A_VAL0, 16'h0000);
    run_for(A_CTRL0, bit_at(DIR_SW), 8);
    expect_reg("core down", A_VAL0, 16'hFFFE);
    check("latch down", 16'(toggle_out), 16'h0001);
    expect_reg("aux latch clk", A_VAL0 + 4'h1, 16'h0001);
    wreg(A_VAL0, 16'h0010);
    dir_lvl <= 3'h1;
    repeat (8) @(posedge clk);
    run_for(A_CTRL0, bit_at(DIR_EXT), 40);
    dir_lvl <= 3'h0;
    expect_reg("dir pin", A_VAL0, 16'h0006);
    $display("test direction done");
    wreg(A_VAL0, 16'h0000);
    run_for(A_CTRL0, 16'(M_GATED) | bit_at(GATE_LVL), 40);
    expect_reg("gate closed", A_VAL0, 16'h0000);
    lvl <= 3'h1;
    repeat (8) @(posedge clk);
    run_for(A_CTRL0, 16'(M_GATED) | bit_at(GATE_LVL), 40);
    lvl <= 3'h0;
    expect_reg("gate open", A_VAL0, 16'h000A);
    $display("test gated done");
    wreg(A_VAL0, 16'h0000);
    wreg(A_CTRL0, 16'(M_COUNTER) | bit_at(RUN) | bit_at(EDGE_RISE));
    repeat (3) pulse(0);
    expect_reg("events", A_VAL0, 16'h0003);
    wreg(A_CTRL0, 16'(M_COUNTER) | bit_at(RUN) | bit_at(EDGE_FALL));
    pulse(0);
    expect_reg("fall events", A_VAL0, 16'h0004);
    wreg(A_VAL0, 16'h0000);
    wreg(A_CTRL0, 16'(M_INCR) | bit_at(RUN));
    quad_on <= 1'b1;
    quad(4, 1'b1);
    expect_reg("position fwd", A_VAL0, 16'h0004);
    quad(6, 1'b0);
    expect_reg("position back", A_VAL0, 16'hFFFE);
    quad(2, 1'b1);
    wreg(A_CTRL0, 16'h0000);
    quad_on <= 1'b0;
    $display("test counter done");
    wreg(A_VAL0, 16'h1234);
    wreg(A_CTRL0 + 4'h1,
         (16'(F_CAPTURE) << FUNC_LSB) | bit_at(EDGE_RISE) | bit_at(RUN));
    wreg(A_VAL0 + 4'h1, 16'h0000);
    wreg(A_STATUS, 16'h001F);
    pulse(1);
    expect_reg("capture", A_VAL0 + 4'h1, 16'h1234);
    expect_reg("capture flag", A_STATUS, bit_at(ST_CAP_A));
    repeat (40) @(posedge clk);
    expect_reg("capture held", A_VAL0 + 4'h1, 16'h1234);
    wreg(A_CTRL0 + 4'h2, (16'(F_CAPTURE) << FUNC_LSB) | bit_at(EDGE_RISE));
    pulse(2);
    expect_reg("capture b", A_VAL0 + 4'h2, 16'h1234);
    expect_reg("capture b flag", A_STATUS, 16'h0018);
    wreg(A_CTRL0 + 4'h2, (16'(F_RELOAD) << FUNC_LSB) | bit_at(EDGE_RISE));
    wreg(A_VAL0 + 4'h2, 16'h0100);
    pulse(2);
    expect_reg("reload pin", A_VAL0, 16'h0100);
    $display("test capture reload done");
    wreg(A_CTRL0 + 4'h1, (16'(F_RELOAD) << FUNC_LSB) | bit_at(RLD_RISE));
    wreg(A_VAL0 + 4'h1, 16'h0002);
    wreg(A_CTRL0 + 4'h2, (16'(F_RELOAD) << FUNC_LSB) | bit_at(RLD_FALL));
    wreg(A_VAL0 + 4'h2, 16'h0004);
    wreg(A_LATCH, 16'h0002);
    wreg(A_VAL0, 16'h0004);
    wreg(A_CTRL0, bit_at(DIR_SW) | bit_at(RUN));
    measure(1'b0, lo);
    measure(1'b1, hi);
    measure(1'b0, lo);
    check("pwm high", 16'(hi), 16'h000C);
    check("pwm low", 16'(lo), 16'h0014);
    $display("test pwm done");
    summarize();
  end
endmodule // test_timer_group
